// ---- hw/ebasc_arbiter.sv ----
// Purpose: external bus arbitration and show cycle control
// Assumes: bus controller reports operand and cycle progress
// Notes: grant pin changes on the falling clock edge
`timescale 1ns/1ps
module ebasc_arbiter (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic bus_request_n_i,
  input wire logic grant_ack_n_i,
  output logic bus_grant_n_o,
  input wire logic op_start_i,
  input wire logic ext_cycle_i,
  input wire logic ext_as_n_i,
  input wire logic [1:0] transfer_size_i,
  input wire logic [1:0] transfer_ack_n_i,
  input wire logic int_start_i,
  input wire logic int_done_i,
  input wire logic int_ext_target_i,
  input wire logic [ebasc_pkg::EBASC_ADDR_W-1:0] int_addr_i,
  input wire logic [ebasc_pkg::EBASC_FC_W-1:0] int_fc_i,
  input wire logic [1:0] int_size_i,
  input wire logic int_rw_i,
  input wire logic [ebasc_pkg::EBASC_DATA_W-1:0] int_wdata_i,
  input wire logic [ebasc_pkg::EBASC_DATA_W-1:0] int_rdata_i,
  input wire logic show_cycle_enable_wr_i,
  input wire logic [1:0] show_cycle_enable_data_i,
  input wire logic test_mode_select_line_i,
  output logic [ebasc_pkg::EBASC_ADDR_W-1:0] addr_o,
  output logic [ebasc_pkg::EBASC_FC_W-1:0] fc_o,
  output logic [1:0] size_o,
  output logic rw_o,
  output logic [ebasc_pkg::EBASC_DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic ctrl_oe_o,
  output logic addr_strobe_n_o,
  output logic data_strobe_n_o,
  output logic [1:0] lane_valid_o,
  output logic int_stall_o,
  output logic ext_master_o,
  output logic slave_mode_o,
  output logic slave_access_o
);
  import ebasc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // true when this acknowledge ends the last cycle of the operand
  function automatic logic last_cycle(input logic [1:0] sz, input logic [1:0] ack_n);
    logic [2:0] need;
    logic [2:0] port;
    need = (sz == 2'h0) ? 3'h4 : {1'b0, sz};
    port = (ack_n == 2'h0) ? 3'h2 : 3'h1;
    last_cycle = (need <= port);
  endfunction

  ebasc_arb_t arb_q, arb_d;
  ebasc_show_t show_q, show_d;
  logic op_busy_q, op_busy_d;
  logic grant_n_q;
  logic float_q, float_d;
  logic [1:0] show_cycle_enable_q;
  logic slave_q;
  logic [EBASC_ADDR_W-1:0] addr_q;
  logic [EBASC_FC_W-1:0] fc_q;
  logic [1:0] size_q;
  logic rw_q;
  logic ext_tgt_q;
  logic [EBASC_DATA_W-1:0] data_q, data_d;
  logic data_oe_q, data_oe_d;

  // ****************************************
  // synchronised request and acknowledge
  // ****************************************
  ebasc_sync_if sif (
    .clk(clk_i),
    .rst(sys_rst_i)
  );

  assign sif.req_raw_n = bus_request_n_i;
  assign sif.ack_raw_n = grant_ack_n_i;

  ebasc_sync u_sync (
    .sif(sif.sync_side)
  );

  wire req_w = sif.req;
  wire ack_w = sif.ack;

  // ****************************************
  // grant hold-off conditions
  // ****************************************
  // last external cycle is judged by size and acknowledge
  wire ack_seen_w = ext_cycle_i && (transfer_ack_n_i != 2'h3);
  wire op_end_w = ack_seen_w && last_cycle(transfer_size_i, transfer_ack_n_i);
  wire show_on_w = (show_cycle_enable_q != EBASC_SHOW_CYCLE_ENABLE_OFF);
  wire show_cycle_enable_halt_w = (show_cycle_enable_q == EBASC_SHOW_CYCLE_ENABLE_HALT);
  // internal traffic delays the grant only in the halting code
  wire int_hold_w = show_cycle_enable_halt_w && (int_start_i || show_q != SHOW_S0);
  // operand coherency, grant only between operands
  wire hold_w = op_busy_q || op_start_i || ext_cycle_i || int_hold_w;
  wire g_w = (arb_q == ARB_GRANT) || (arb_q == ARB_REGRANT);
  // T only once an outside master has acknowledged; a bare grant keeps our drivers on
  wire t_w = (arb_q == ARB_EXT) || (arb_q == ARB_REGRANT);

  // operand tracking; a new start wins over the end of the old one
  always_comb begin
    op_busy_d = op_busy_q;
    if (op_end_w) begin
      op_busy_d = 1'b0;
    end
    if (op_start_i) begin
      op_busy_d = 1'b1;
    end
  end

  // ****************************************
  // arbitration state machine
  // ****************************************
  // outside requests wait out operands, bus cycles and halting-code internal traffic; no fault gating here
  always_comb begin
    arb_d = arb_q;
    case (arb_q)
      // stay owner while request and acknowledge are idle
      ARB_IDLE: begin
        if (ack_w) begin
          arb_d = ARB_EXT;
        end else if (req_w && !hold_w) begin
          arb_d = ARB_GRANT;
        end
      end
      // no acknowledge and no request, keep the bus
      ARB_GRANT: begin
        if (ack_w) begin
          arb_d = ARB_EXT;
        end else if (!req_w) begin
          arb_d = ARB_IDLE;
        end
      end
      // a request held past acknowledge earns another grant
      ARB_EXT: begin
        if (ack_w && req_w) begin
          arb_d = ARB_REGRANT;
        end else if (!ack_w) begin
          // pending requests keep the bus outside
          arb_d = req_w ? ARB_GRANT : ARB_IDLE;
        end
      end
      // grant reasserted so the next master can be picked early
      ARB_REGRANT: begin
        if (!ack_w) begin
          arb_d = req_w ? ARB_GRANT : ARB_IDLE;
        end else if (!req_w) begin
          arb_d = ARB_EXT;
        end
      end
      default: begin
        arb_d = ARB_IDLE;
      end
    endcase
  end

  // float once address strobe is seen negated under T
  assign float_d = t_w && (float_q || ext_as_n_i);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arb_q <= ARB_IDLE;
      op_busy_q <= 1'b0;
      float_q <= 1'b0;
    end else begin
      arb_q <= arb_d;
      op_busy_q <= op_busy_d;
      float_q <= float_d;
    end
  end

  // grant pin moves on the falling edge after the state
  always_ff @(negedge clk_i) begin
    if (sys_rst_i) begin
      grant_n_q <= 1'b1;
    end else begin
      grant_n_q <= ~g_w;
    end
  end

  // ****************************************
  // configuration set at reset and by show enable writes
  // ****************************************
  // show enable cleared by reset; strap sampled during reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      show_cycle_enable_q <= EBASC_SHOW_CYCLE_ENABLE_RST;
      slave_q <= ~test_mode_select_line_i;
    end else if (show_cycle_enable_wr_i) begin
      show_cycle_enable_q <= show_cycle_enable_data_i;
    end
  end

  // ****************************************
  // show cycle sequencer
  // ****************************************
  // S0, S41, S42 waits for the internal access to finish, S43
  always_comb begin
    show_d = show_q;
    case (show_q)
      SHOW_S0: begin
        if (int_start_i && show_on_w && !t_w) begin
          show_d = SHOW_S41;
        end
      end
      SHOW_S41: begin
        show_d = SHOW_S42;
      end
      SHOW_S42: begin
        if (int_done_i) begin
          show_d = SHOW_S43;
        end
      end
      SHOW_S43: begin
        show_d = SHOW_S0;
      end
      default: begin
        show_d = SHOW_S0;
      end
    endcase
  end

  // external byte write is copied onto both halves
  wire byte_dup_w = (int_size_i == EBASC_SIZE_BYTE) && !int_rw_i && int_ext_target_i;
  wire [EBASC_DATA_W-1:0] wdata_w = byte_dup_w ?
    (int_addr_i[0] ? {2{int_wdata_i[7:0]}} : {2{int_wdata_i[15:8]}}) : int_wdata_i;
  assign data_d = (show_q == SHOW_S42 && int_done_i) ? (int_rw_i ? int_rdata_i : wdata_w)
                                                     : data_q;
  // data drive starts in S43 and lasts through the next S0
  assign data_oe_d = (show_d == SHOW_S43) || (show_q == SHOW_S43);

  // address and controls follow internal activity regardless of show mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      show_q <= SHOW_S0;
      addr_q <= '0;
      fc_q <= '0;
      size_q <= '0;
      rw_q <= 1'b1;
      ext_tgt_q <= 1'b0;
      data_q <= '0;
      data_oe_q <= 1'b0;
    end else begin
      show_q <= show_d;
      data_q <= data_d;
      data_oe_q <= data_oe_d;
      if (int_start_i && show_q == SHOW_S0) begin
        addr_q <= int_addr_i;
        fc_q <= int_fc_i;
        size_q <= int_size_i;
        rw_q <= int_rw_i;
        ext_tgt_q <= int_ext_target_i;
      end
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  assign bus_grant_n_o = grant_n_q;
  assign addr_o = addr_q;
  assign fc_o = fc_q;
  assign size_o = size_q;
  assign rw_o = rw_q;
  assign data_o = data_q;
  // data strobe asserted in S41 and S42 only while enabled
  assign data_strobe_n_o = !(show_on_w && (show_q == SHOW_S41 || show_q == SHOW_S42));
  // show cycles never raise the address strobe
  assign addr_strobe_n_o = ext_as_n_i || (show_q != SHOW_S0);
  assign data_oe_o = data_oe_q && show_on_w && !t_w;
  // controls return at once when the state returns to zero
  assign ctrl_oe_o = !(t_w && float_q);
  // lanes picked from size and low address bit
  assign lane_valid_o = (size_q == EBASC_SIZE_BYTE && !ext_tgt_q) ?
    (addr_q[0] ? 2'h1 : 2'h2) : 2'h3;
  // halting code stops internal bus while an outside master runs
  assign int_stall_o = show_cycle_enable_halt_w && t_w;
  assign ext_master_o = t_w;
  assign slave_mode_o = slave_q;
  // slave access opens with the grant
  assign slave_access_o = slave_q && !grant_n_q;

  // ****************************************
  // checks
  // ****************************************
  a_grant_pin_state: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(!sys_rst_i) |-> (bus_grant_n_o == !g_w))
    else $error("grant pin does not follow arbiter state");

  a_grant_waits_operand: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arb_q == ARB_IDLE && hold_w && !ack_w) |=> arb_q == ARB_IDLE)
    else $error("grant given during an operand transfer");

  a_idle_holds_owner: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arb_q == ARB_IDLE && !req_w && !ack_w) |=> (arb_q == ARB_IDLE && ctrl_oe_o))
    else $error("arbiter left state zero without request or acknowledge");

  a_no_ack_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arb_q == ARB_GRANT && !ack_w && !req_w) |=> ##1 bus_grant_n_o)
    else $error("grant not withdrawn when nobody acknowledged");

  a_pending_regrant: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arb_q == ARB_EXT && ack_w && req_w) |=> ##1 !bus_grant_n_o)
    else $error("pending request not granted again");

  a_no_takeback: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (arb_q != ARB_IDLE && !ack_w && req_w) |=> arb_q != ARB_IDLE)
    else $error("bus retaken with a request pending");

  a_float_after_as: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (t_w && ext_as_n_i) ##1 t_w |-> !ctrl_oe_o)
    else $error("pins not floated after address strobe negated");

  a_show_ds_seq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (show_q == SHOW_S0 && show_d == SHOW_S41) |=> !data_strobe_n_o ##1 !data_strobe_n_o)
    else $error("data strobe not asserted in S41 and S42");

  a_show_data_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (show_q == SHOW_S43) |=> data_oe_q)
    else $error("show data not held through S0");

  a_show_no_as: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (show_q != SHOW_S0) |-> addr_strobe_n_o)
    else $error("address strobe asserted during a show cycle");

  a_show_cycle_enable_reset: assert property (@(posedge clk_i)
    sys_rst_i |=> (show_cycle_enable_q == EBASC_SHOW_CYCLE_ENABLE_OFF))
    else $error("show enable not cleared by reset");

  a_show_off_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !show_on_w |-> (data_strobe_n_o && !data_oe_o))
    else $error("strobe or data driven with show cycles off");

  a_slave_access: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    slave_access_o |-> (slave_q && !bus_grant_n_o))
    else $error("slave access without slave mode and grant");

endmodule // ebasc_arbiter

// ---- hw/ebasc_pkg.sv ----
// Purpose: shared constants and types for the external bus arbiter
// Assumes: one system clock, synchronous active-high reset
// Notes: show enable encodings and size codes live here
package ebasc_pkg;

  // ****************************************
  // show cycle enable field
  // ****************************************
  localparam logic [1:0] EBASC_SHOW_CYCLE_ENABLE_OFF = 2'h0;   // show cycles disabled
  localparam logic [1:0] EBASC_SHOW_CYCLE_ENABLE_HALT = 2'h3;  // show on, internal stalls under external master
  localparam logic [1:0] EBASC_SHOW_CYCLE_ENABLE_RST = 2'h0;

  // ****************************************
  // transfer size codes and widths
  // ****************************************
  localparam logic [1:0] EBASC_SIZE_BYTE = 2'h1;
  localparam logic [1:0] EBASC_SIZE_WORD = 2'h2;
  localparam int EBASC_ADDR_W = 24;
  localparam int EBASC_DATA_W = 16;
  localparam int EBASC_FC_W = 3;

  // ****************************************
  // timing and reset values
  // ****************************************
  localparam int EBASC_SYNC_STAGES = 2;           // request and acknowledge synchroniser depth
  localparam logic EBASC_SLAVE_RST = 1'b0;

  typedef enum logic [2:0] {
    ARB_IDLE, ARB_GRANT, ARB_EXT, ARB_REGRANT
  } ebasc_arb_t;

  typedef enum logic [1:0] {
    SHOW_S0, SHOW_S41, SHOW_S42, SHOW_S43
  } ebasc_show_t;

endpackage

// ---- hw/ebasc_sync_if.sv ----
// Purpose: carries raw and synchronised arbitration inputs
// Assumes: raw inputs active low, synced outputs active high
// Notes: used only between the arbiter and its synchroniser
`timescale 1ns/1ps
interface ebasc_sync_if (
  input wire logic clk,
  input wire logic rst
);
  logic req_raw_n;
  logic ack_raw_n;
  logic req;
  logic ack;

  modport sync_side (input clk, input rst, input req_raw_n, input ack_raw_n, output req, output ack);
  modport user (output req_raw_n, output ack_raw_n, input req, input ack);
endinterface

// ---- hw/ebasc_sync.sv ----
// Purpose: two-flop synchroniser for request and acknowledge
// Assumes: inputs may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module ebasc_sync (
  ebasc_sync_if.sync_side sif
);
  import ebasc_pkg::*;

  logic [1:0] meta_q;
  logic [1:0] stab_q;

  // ****************************************
  // synchroniser stages
  // ****************************************
  // two-clock synchronising
  always_ff @(posedge sif.clk) begin
    if (sif.rst) begin
      meta_q <= 2'h3;
      stab_q <= 2'h3;
    end else begin
      meta_q <= {sif.ack_raw_n, sif.req_raw_n};
      stab_q <= meta_q;
    end
  end

  // active-high versions of the low-true pins
  assign sif.req = ~stab_q[0];
  assign sif.ack = ~stab_q[1];

  // request seen within two clocks
  a_sync_req_latency: assert property (@(posedge sif.clk) disable iff (sif.rst)
    (!sif.req_raw_n ##1 !sif.req_raw_n) |=> sif.req)
    else $error("request not synchronised within two clocks");

  // acknowledge seen within two clocks
  a_sync_ack_latency: assert property (@(posedge sif.clk) disable iff (sif.rst)
    (!sif.ack_raw_n ##1 !sif.ack_raw_n) |=> sif.ack)
    else $error("acknowledge not synchronised within two clocks");

endmodule // ebasc_sync

// ---- sim/ebasc_master_model.sv ----
// Purpose: outside bus master for arbitration scenarios
// Assumes: grant sampled on rising clock edges
// Notes: request idles high, as a pulled-up wired-OR line would
`timescale 1ns/1ps
module ebasc_master_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic keep_req_i,
  input wire logic no_ack_i,
  input wire logic [7:0] hold_i,
  input wire logic bus_grant_n_i,
  output logic bus_request_n_o,
  output logic grant_ack_n_o
);
  // ****************************************
  // request, take and release
  // ****************************************
  logic [1:0] st_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= 2'h0;
      cnt_q <= 8'h0;
      bus_request_n_o <= 1'b1;
      grant_ack_n_o <= 1'b1;
    end else if (st_q == 2'h0 && start_i) begin
      bus_request_n_o <= 1'b0;
      st_q <= 2'h1;
    end else if (st_q == 2'h1 && !bus_grant_n_i && grant_ack_n_o) begin
      // take only with grant and idle ack; a no-ack run just walks away
      bus_request_n_o <= no_ack_i | !keep_req_i;
      grant_ack_n_o <= no_ack_i;
      cnt_q <= hold_i;
      st_q <= no_ack_i ? 2'h0 : 2'h2;
    end else if (st_q == 2'h2) begin
      // ack held for every owned cycle
      cnt_q <= cnt_q - 8'h1;
      if (cnt_q == 8'h0) begin
        grant_ack_n_o <= 1'b1;
        bus_request_n_o <= 1'b1;
        st_q <= 2'h0;
      end
    end
  end
endmodule // ebasc_master_model

// ---- sim/ebasc_arbiter_test.sv ----
// Purpose: self-checking bench for the bus arbiter
// Assumes: master model is the outside requester
// Notes: inputs by nba at rising edges, outputs read 1 ns later
`timescale 1ns/1ps
module ebasc_arbiter_test;
  import ebasc_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go, keep, noack, op_st, ext_cyc, as_n, i_st, i_done, i_ext, i_rw, sh_wr, tsel;
  logic [7:0] hold;
  logic [1:0] tsize, tack_n, isize, show_cycle_enable, size_o, lanes;
  logic [EBASC_ADDR_W-1:0] iaddr, addr_o;
  logic [EBASC_FC_W-1:0] ifc, fc_o;
  logic [EBASC_DATA_W-1:0] wdata, rdata, data_o;
  logic req_n, ack_n, gnt_n, rw_o, d_oe, c_oe, as_o, ds_n, stall, extm, slv, slv_acc;
  int miscompares = 0;
  int n_compared = 0;
  int nw;
  always #20 clk_i = ~clk_i;
  ebasc_master_model MST (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(go),
    .keep_req_i(keep), .no_ack_i(noack), .hold_i(hold), .bus_grant_n_i(gnt_n),
    .bus_request_n_o(req_n), .grant_ack_n_o(ack_n));
  ebasc_arbiter DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_request_n_i(req_n),
    .grant_ack_n_i(ack_n), .bus_grant_n_o(gnt_n), .op_start_i(op_st), .ext_cycle_i(ext_cyc),
    .ext_as_n_i(as_n), .transfer_size_i(tsize), .transfer_ack_n_i(tack_n), .int_start_i(i_st),
    .int_done_i(i_done), .int_ext_target_i(i_ext), .int_addr_i(iaddr), .int_fc_i(ifc),
    .int_size_i(isize), .int_rw_i(i_rw), .int_wdata_i(wdata), .int_rdata_i(rdata),
    .show_cycle_enable_wr_i(sh_wr), .show_cycle_enable_data_i(show_cycle_enable), .test_mode_select_line_i(tsel), .addr_o(addr_o),
    .fc_o(fc_o), .size_o(size_o), .rw_o(rw_o), .data_o(data_o), .data_oe_o(d_oe),
    .ctrl_oe_o(c_oe), .addr_strobe_n_o(as_o), .data_strobe_n_o(ds_n), .lane_valid_o(lanes),
    .int_stall_o(stall), .ext_master_o(extm), .slave_mode_o(slv), .slave_access_o(slv_acc));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return gnt_n;
      1: return ack_n;
      2: return c_oe;
      default: return ds_n;
    endcase
  endfunction
  // bounded poll; running out ends the run
  task automatic wait_lvl(int k, logic lvl, int max);
    nw = 0;
    while (pick(k) !== lvl && nw < max) begin
      @(posedge clk_i);
      #1;
      nw++;
    end
    if (pick(k) !== lvl) begin
      miscompares++;
      $display("unexpected level on watch %0d: expected %b, seen %b", k, lvl, pick(k));
      end_sim();
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start_m(logic [7:0] h, logic k, logic na);
    @(posedge clk_i);
    hold <= h;
    keep <= k;
    noack <= na;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic own_end;
    wait_lvl(1, 1'b1, 16);
    wait_lvl(2, 1'b1, 6);
  endtask
  task automatic set_show_cycle_enable(logic [1:0] v);
    @(posedge clk_i);
    sh_wr <= 1'b1;
    show_cycle_enable <= v;
    @(posedge clk_i);
    sh_wr <= 1'b0;
  endtask
  task automatic int_pulse(logic done);
    @(posedge clk_i);
    if (done) i_done <= 1'b1;
    else i_st <= 1'b1;
    @(posedge clk_i);
    i_done <= 1'b0;
    i_st <= 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // idle after reset
  task automatic t_reset;
    cyc(4);
    #1;
    chk("grant", 1, gnt_n);
    chk("ctrl drive", 1, c_oe);
    chk("data drive", 0, d_oe);
    chk("data strobe", 1, ds_n);
    chk("outside owner", 0, extm);
    chk("slave mode", 0, slv);
  endtask
  task automatic t_basic;
    start_m(8'h6, 1'b0, 1'b0);
    wait_lvl(0, 1'b0, 8);
    chk("grant delay in range", 1, nw >= 2 && nw <= 5);
    wait_lvl(1, 1'b0, 3);
    wait_lvl(2, 1'b0, 6);
    chk("outside owner", 1, extm);
    wait_lvl(0, 1'b1, 5);
    own_end();
    chk("grant after release", 1, gnt_n);
  endtask
  task automatic t_noack;
    start_m(8'h1, 1'b0, 1'b1);
    wait_lvl(0, 1'b0, 8);
    repeat (6) begin
      @(posedge clk_i);
      #1;
      chk("drive kept", 1, c_oe);
    end
    chk("grant withdrawn", 1, gnt_n);
    chk("outside owner", 0, extm);
  endtask
  // one acked bus cycle after an operand gap
  task automatic bus_cyc(logic [1:0] a);
    cyc(5);
    #1;
    chk("grant held in operand", 1, gnt_n);
    @(posedge clk_i);
    ext_cyc <= 1'b1;
    tack_n <= a;
    @(posedge clk_i);
    ext_cyc <= 1'b0;
    tack_n <= 2'h3;
    tsize <= EBASC_SIZE_BYTE;
  endtask
  // word on byte port keeps the bus
  task automatic t_coh;
    @(posedge clk_i);
    op_st <= 1'b1;
    tsize <= EBASC_SIZE_WORD;
    @(posedge clk_i);
    op_st <= 1'b0;
    start_m(8'h2, 1'b0, 1'b0);
    bus_cyc(2'h2);
    bus_cyc(2'h2);
    wait_lvl(0, 1'b0, 8);
    own_end();
  endtask
  // held request gets a fresh grant
  task automatic t_regrant;
    start_m(8'h8, 1'b1, 1'b0);
    wait_lvl(0, 1'b0, 8);
    wait_lvl(1, 1'b0, 3);
    wait_lvl(0, 1'b1, 6);
    wait_lvl(0, 1'b0, 8);
    chk("still acknowledged", 0, ack_n);
    wait_lvl(1, 1'b1, 12);
    wait_lvl(2, 1'b1, 8);
  endtask
  task automatic t_show;
    logic [15:0] exp[2] = '{16'hc3c3, 16'h1234};
    set_show_cycle_enable(2'h1);
    for (int i = 0; i < 2; i++) begin
      i_rw <= i[0];
      i_ext <= 1'b1;
      isize <= i[0] ? EBASC_SIZE_WORD : EBASC_SIZE_BYTE;
      iaddr <= 24'h001235 + 24'(i * 11);
      wdata <= 16'h00c3;
      rdata <= 16'h1234;
      int_pulse(1'b0);
      #1;
      chk("strobe in s41", 0, ds_n);
      chk("show address", 24'h001235 + i * 11, addr_o);
      chk("address strobe", 1, as_o);
      cyc(3);
      #1;
      chk("strobe in s42", 0, ds_n);
      int_pulse(1'b1);
      #1;
      wait_lvl(3, 1'b1, 3);
      chk("show data", exp[i], data_o);
      chk("lanes", 3, lanes);
      chk("data drive", 1, d_oe);
      @(posedge clk_i);
      #1;
      chk("data drive in s0", 1, d_oe);
      @(posedge clk_i);
    end
  endtask
  task automatic t_off;
    set_show_cycle_enable(2'h0);
    iaddr <= 24'h00abcd;
    int_pulse(1'b0);
    repeat (3) begin
      @(posedge clk_i);
      #1;
      chk("strobe off", 1, ds_n);
      chk("data float", 0, d_oe);
    end
    chk("address follows", 24'h00abcd, addr_o);
    int_pulse(1'b1);
  endtask
  // internal access holds grant, then stalls
  task automatic t_stall;
    set_show_cycle_enable(2'h3);
    int_pulse(1'b0);
    start_m(8'h4, 1'b0, 1'b0);
    cyc(6);
    #1;
    chk("grant held for internal", 1, gnt_n);
    int_pulse(1'b1);
    wait_lvl(0, 1'b0, 8);
    wait_lvl(1, 1'b0, 3);
    wait_lvl(2, 1'b0, 6);
    chk("internal stall", 1, stall);
    own_end();
    chk("stall released", 0, stall);
    set_show_cycle_enable(2'h0);
  endtask
  // strap low in reset, grant opens access
  task automatic t_slave;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    tsel <= 1'b0;
    cyc(5);
    sys_rst_i <= 1'b0;
    tsel <= 1'b1;
    start_m(8'h3, 1'b0, 1'b0);
    #1;
    chk("slave mode", 1, slv);
    chk("no access before grant", 0, slv_acc);
    wait_lvl(0, 1'b0, 8);
    chk("slave access", 1, slv_acc);
    wait_lvl(1, 1'b1, 16);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {go, keep, noack, op_st, ext_cyc, i_st, i_done, i_ext, sh_wr} = '0;
    {as_n, i_rw, tsel, tack_n} = '1;
    {hold, tsize, isize, show_cycle_enable, iaddr, ifc, wdata, rdata} = '0;
    cyc(5);
    sys_rst_i <= 1'b0;
    t_reset();
    t_basic();
    t_noack();
    t_coh();
    t_regrant();
    t_show();
    t_off();
    t_stall();
    t_slave();
    end_sim();
  end
endmodule // ebasc_arbiter_test
